// ==== src/arw_result_regs.v ====
// Result, window threshold and clock tuning registers of the converter
// Function
// R1 - One shared staging byte, software readable and writable
// R2 - Result word at 0x10/0x11, read only
// R3 - Single sample clamps to full scale or zero
// R4 - Accumulated result never exceeds the ceiling
// R5 - Ten-bit sample sits in result bits 9:0
// R6 - Results are unsigned, zero to full scale
// R7 - Window compares the finished sum only
// R8 - Low threshold word at 0x12, resets zero
// R9 - High threshold word at 0x14, resets zero
// R10 - Duty select bit chooses clock waveform
// R11 - Result read or write-one clears flags
// R12 - Window mode decides when match flag sets
// R13 - Low byte stages, high byte commits atomically
//
// The Wishbone interface to the registers was left to the implementer.
`include "arw_defs.vh"

module arw_result_regs #(
   parameter ACC_W = 16
) (
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Converter core
   input  wire        conv_valid,
   input  wire        conv_first,
   input  wire        conv_last,
   input  wire        conv_over,
   input  wire        conv_under,
   input  wire [9:0]  conv_sample,
   output reg         clock_duty_select,
   output reg         irq
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg [7:0]       stage_q;
   reg [15:0]      conversion_output_value_q;
   reg [15:0]      window_low_threshold_q;
   reg [15:0]      window_high_threshold_q;
   reg [ACC_W-1:0] acc_q;
   reg             conversion_done_flag_q;
   reg             window_match_flag_q;
   reg [1:0]       mask_q;
   reg [2:0]       window_mode_select_q;

   // ----------------------------------------
   // Sample conditioning and accumulation
   // ----------------------------------------
   reg  [9:0]  sample_c;
   reg  [16:0] sum_c;
   reg  [15:0] acc_d;
   reg         hit_c;

   always @* begin
      // Pins beyond the reference or below ground pin the code
      if (conv_over)
         sample_c = `ARW_SAMPLE_MAX;                        // [R3]
      else if (conv_under)
         sample_c = `ARW_SAMPLE_MIN;                        // [R3]
      else
         sample_c = conv_sample;
      // Sample sits in the low bits, unsigned            [R5] [R6]
      if (conv_first)
         sum_c = {7'h00, sample_c};
      else
         sum_c = {1'b0, acc_q[15:0]} + {7'h00, sample_c};
      // 64 x 0x3FF fits; saturate only if a core overruns the count
      if (sum_c > {1'b0, `ARW_ACC_CEIL})
         acc_d = `ARW_ACC_CEIL;                             // [R4]
      else
         acc_d = sum_c[15:0];
   end

   // Compare the finished sum, never the single sample      [R7]
   always @* begin
      case (window_mode_select_q)                           // [R12]
         `ARW_WM_BELOW:
            hit_c = acc_d < window_low_threshold_q;
         `ARW_WM_ABOVE:
            hit_c = acc_d > window_high_threshold_q;
         `ARW_WM_INSIDE:
            hit_c = (acc_d > window_low_threshold_q) &&
                    (acc_d < window_high_threshold_q);
         `ARW_WM_OUTSIDE:
            hit_c = (acc_d < window_low_threshold_q) ||
                    (acc_d > window_high_threshold_q);
         default:
            hit_c = 1'b0;
      endcase
   end

   wire finish = conv_valid & conv_last;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr    = req & wb_we_i & wb_sel_i[0];
   wire       rd    = req & ~wb_we_i;
   wire [7:0] wbyte = wb_dat_i[7:0];
   wire       res_l_rd = rd & (wb_adr_i == `ARW_OFS_RES_L);
   wire       clr_done  = res_l_rd | (wr & (wb_adr_i == `ARW_OFS_FLAGS)
                          & wbyte[`ARW_BIT_DONE]);
   wire       clr_match = res_l_rd | (wr & (wb_adr_i == `ARW_OFS_FLAGS)
                          & wbyte[`ARW_BIT_MATCH]);

   reg [7:0] rdata_c;
   always @* begin
      case (wb_adr_i)
         `ARW_OFS_STAGE: rdata_c = stage_q;                 // [R1]
         `ARW_OFS_RES_L: rdata_c = conversion_output_value_q[7:0];
         `ARW_OFS_RES_H: rdata_c = stage_q;
         `ARW_OFS_WLO_L: rdata_c = window_low_threshold_q[7:0];
         `ARW_OFS_WLO_H: rdata_c = stage_q;
         `ARW_OFS_WHI_L: rdata_c = window_high_threshold_q[7:0];
         `ARW_OFS_WHI_H: rdata_c = stage_q;
         `ARW_OFS_TUNE:  rdata_c = {7'h00, clock_duty_select};
         `ARW_OFS_FLAGS: rdata_c = {6'h00, window_match_flag_q,
                                    conversion_done_flag_q};
         `ARW_OFS_MASK:  rdata_c = {6'h00, mask_q};
         `ARW_OFS_MODE:  rdata_c = {5'h00, window_mode_select_q};
         default:        rdata_c = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Bus answer: one wait-free cycle, ack for one cycle
   // ----------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? {24'h00_0000, rdata_c} : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         stage_q                   <= `ARW_RST_BYTE;
         conversion_output_value_q <= `ARW_RST_WORD;
         window_low_threshold_q    <= `ARW_RST_WORD;        // [R8]
         window_high_threshold_q   <= `ARW_RST_WORD;        // [R9]
         acc_q                     <= {ACC_W{1'b0}};
         clock_duty_select         <= `ARW_RST_DUTY;        // [R10]
         mask_q                    <= 2'h0;
         window_mode_select_q      <= `ARW_WM_NONE;
      end else begin
         if (conv_valid)
            acc_q <= acc_d[ACC_W-1:0];
         if (finish)
            conversion_output_value_q <= acc_d;             // [R2]
         // Low-byte read latches the high half for a coherent pair
         if (rd) begin
            case (wb_adr_i)
               `ARW_OFS_RES_L:
                  stage_q <= conversion_output_value_q[15:8]; // [R13]
               `ARW_OFS_WLO_L:
                  stage_q <= window_low_threshold_q[15:8];  // [R13]
               `ARW_OFS_WHI_L:
                  stage_q <= window_high_threshold_q[15:8]; // [R13]
               default: ;
            endcase
         end
         if (wr) begin
            case (wb_adr_i)
               `ARW_OFS_STAGE: stage_q <= wbyte;            // [R1]
               `ARW_OFS_WLO_L: stage_q <= wbyte;            // [R13]
               `ARW_OFS_WHI_L: stage_q <= wbyte;            // [R13]
               `ARW_OFS_WLO_H:
                  window_low_threshold_q <= {wbyte, stage_q};  // [R8] [R13]
               `ARW_OFS_WHI_H:
                  window_high_threshold_q <= {wbyte, stage_q}; // [R9] [R13]
               `ARW_OFS_TUNE:
                  clock_duty_select <= wbyte[`ARW_BIT_DUTY]; // [R10]
               `ARW_OFS_MASK:  mask_q <= wbyte[1:0];
               `ARW_OFS_MODE:  window_mode_select_q <= wbyte[2:0];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Sticky flags: a finishing conversion beats a same-cycle clear
   // ----------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         conversion_done_flag_q <= 1'b0;
         window_match_flag_q    <= 1'b0;
         irq                    <= 1'b0;
      end else begin
         if (finish)
            conversion_done_flag_q <= 1'b1;
         else if (clr_done)
            conversion_done_flag_q <= 1'b0;                 // [R11]
         if (finish & hit_c)
            window_match_flag_q <= 1'b1;                    // [R12]
         else if (clr_match)
            window_match_flag_q <= 1'b0;                    // [R11]
         irq <= |({window_match_flag_q, conversion_done_flag_q} & mask_q);
      end
   end

endmodule

// ==== src/arw_defs.vh ====
// Register map, field positions, reset values and encodings of the result block
`ifndef ARW_DEFS_VH
`define ARW_DEFS_VH

// ----------------------------------------
// Register offsets (byte index on the bus)
// ----------------------------------------
`define ARW_OFS_STAGE     8'h0D
`define ARW_OFS_RES_L     8'h10
`define ARW_OFS_RES_H     8'h11
`define ARW_OFS_WLO_L     8'h12
`define ARW_OFS_WLO_H     8'h13
`define ARW_OFS_WHI_L     8'h14
`define ARW_OFS_WHI_H     8'h15
`define ARW_OFS_TUNE      8'h16
`define ARW_OFS_FLAGS     8'h18
`define ARW_OFS_MASK      8'h19
`define ARW_OFS_MODE      8'h1A

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ARW_BIT_DONE      0
`define ARW_BIT_MATCH     1
`define ARW_BIT_DUTY      0
`define ARW_RST_TUNE      8'h01
`define ARW_RST_DUTY      1'b1
`define ARW_RST_BYTE      8'h00
`define ARW_RST_WORD      16'h0000
`define ARW_SAMPLE_MAX    10'h3FF
`define ARW_SAMPLE_MIN    10'h000
`define ARW_ACC_CEIL      16'hFFC0
`define ARW_MAX_ACC       64

// ----------------------------------------
// Window modes
// ----------------------------------------
`define ARW_WM_NONE       3'h0
`define ARW_WM_BELOW      3'h1
`define ARW_WM_ABOVE      3'h2
`define ARW_WM_INSIDE     3'h3
`define ARW_WM_OUTSIDE    3'h4

`endif

// ==== testbench/arw_result_regs_chk.sv ====
// Port-level timing checker for the result register block
`include "arw_defs.vh"
module arw_result_regs_chk (
   // Clock and reset
   input logic        clk, sys_rst,
   // Bus
   input logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input logic [7:0]  wb_adr_i,
   input logic [3:0]  wb_sel_i,
   input logic [31:0] wb_dat_i, wb_dat_o,
   // Converter side
   input logic        conv_valid, conv_first, conv_last,
   input logic        conv_over, conv_under,
   input logic [9:0]  conv_sample,
   input logic        clock_duty_select, irq
);
   timeunit 1ns;
   timeprecision 1ns;
   wire tk  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire lst = conv_valid & conv_last;
   wire wtn = tk & wb_we_i & (wb_adr_i == `ARW_OFS_TUNE);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (tk |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_duty_write: assert property (wtn && wb_sel_i[0] |=>
      clock_duty_select == $past(wb_dat_i[0]))
      else $error("duty select not written");
   a_duty_hold: assert property (!wtn |=> $stable(clock_duty_select))
      else $error("duty select changed without write");
   a_unmapped_zero: assert property (tk && !wb_we_i && wb_adr_i > 8'h1A
      |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_irq_clear: assert property (tk && !wb_we_i &&
      wb_adr_i == `ARW_OFS_RES_L && !lst ##1 !lst |=> !irq)
      else $error("irq stays after result read");
   a_rst_vals: assert property (disable iff (1'b0) sys_rst |=>
      clock_duty_select && !irq && !wb_ack_o)
      else $error("wrong values in reset");
   cover property (tk && wb_we_i);
   cover property (lst ##2 irq);
   cover property ($fell(clock_duty_select));
endmodule
bind arw_result_regs arw_result_regs_chk u_chk (.*);

// ==== testbench/arw_result_regs_tb.sv ====
// Self-checking bench of the result register block
`include "arw_defs.vh"
module arw_result_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0, wb_ack_o, clock_duty_select, irq;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic conv_valid = 1'h0, conv_first = 1'h0, conv_last = 1'h0;
   logic conv_over = 1'h0, conv_under = 1'h0;
   logic [9:0] conv_sample = 10'h000;
   int mismatches = 0, total_checks = 0;
   typedef struct {bit w; logic [7:0] a, d;} arw_row_t;
   // Rows: write flag, offset, data written or read back expected
   arw_row_t rows [21] = '{
      '{1'h0, 8'h16, 8'h01}, '{1'h0, 8'h12, 8'h00},
      '{1'h0, 8'h13, 8'h00}, '{1'h0, 8'h14, 8'h00},
      '{1'h1, 8'h12, 8'h34}, '{1'h0, 8'h0D, 8'h34},
      '{1'h1, 8'h13, 8'h12}, '{1'h0, 8'h12, 8'h34},
      '{1'h0, 8'h13, 8'h12}, '{1'h1, 8'h14, 8'h78},
      '{1'h1, 8'h15, 8'h56}, '{1'h0, 8'h14, 8'h78},
      '{1'h0, 8'h0D, 8'h56}, '{1'h0, 8'h15, 8'h56},
      '{1'h1, 8'h0D, 8'hA5}, '{1'h0, 8'h0D, 8'hA5},
      '{1'h1, 8'h16, 8'h00}, '{1'h0, 8'h16, 8'h00},
      '{1'h0, 8'h40, 8'h00}, '{1'h1, 8'h1A, 8'h03},
      '{1'h1, 8'h19, 8'h03}};
   always #20 clk = ~clk;
   arw_result_regs DUT (.*);
   // ----------------
   // Compare and bus tasks
   // ----------------
   task c8(input logic [7:0] a, e, s);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value reg %h expected %h seen %h", a, e, s);
      end
   endtask
   task c1(input string n, input logic e, s);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", n, e, s);
      end
   endtask
   task x(input bit w, input logic [7:0] a, d);
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, w, a};
      wb_dat_i <= {24'h0, d};
      do @(posedge clk); while (wb_ack_o !== 1'h1);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (!w) c8(a, d, wb_dat_o[7:0]);
   endtask
   // One sum of n samples, last one closes it
   task conv(input int n, input logic [9:0] s, input logic o, u);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         {conv_valid, conv_first, conv_last} <= {1'h1, i == 0, i == n - 1};
         {conv_over, conv_under, conv_sample} <= {o, u, s};
      end
      @(posedge clk);
      {conv_valid, conv_last} <= 2'h0;
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      #1;
      c1("duty", 1'h1, clock_duty_select);
      foreach (rows[i]) x(rows[i].w, rows[i].a, rows[i].d);
      conv(64, 10'h000, 1'h1, 1'h0);
      x(0, 8'h18, 8'h01);
      c1("irq", 1'h1, irq);
      x(1, 8'h10, 8'h55);
      x(0, 8'h10, 8'hC0);
      x(0, 8'h11, 8'hFF);
      x(0, 8'h18, 8'h00);
      conv(5, 10'h3FF, 1'h0, 1'h0);
      x(0, 8'h18, 8'h03);
      x(1, 8'h18, 8'h01);
      x(0, 8'h18, 8'h02);
      x(0, 8'h10, 8'hFB);
      x(0, 8'h11, 8'h13);
      conv(1, 10'h3FF, 1'h0, 1'h1);
      x(0, 8'h10, 8'h00);
      for (int m = 0; m < 5; m++) begin
         x(1, 8'h1A, m[7:0]);
         conv(1, 10'h2A5, 1'h0, 1'h0);
         x(0, 8'h18, {6'h0, m == 1 || m == 4, 1'h1});
         x(0, 8'h10, 8'hA5);
         x(0, 8'h11, 8'h02);
         c1("irq", 1'h0, irq);
      end
      // A real hit in the above mode, full-scale sum over the high limit
      x(1, 8'h1A, 8'h02);
      conv(64, 10'h3FF, 1'h0, 1'h0);
      x(0, 8'h18, 8'h03);
      x(0, 8'h10, 8'hC0);
      // Reset in mid-run must bring back the reset values
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      x(0, 8'h16, 8'h01);
      x(0, 8'h12, 8'h00);
      x(0, 8'h14, 8'h00);
      x(0, 8'h15, 8'h00);
      c1("irq", 1'h0, irq);
      final_report();
   end
endmodule
